// ===== inc/sysclk_boot_defs.vh
// Constants for the system clock and boot control block
`ifndef SYSCLK_BOOT_DEFS_VH
`define SYSCLK_BOOT_DEFS_VH

`define CORE_CLK_MHZ 250
`define SLOW_RC_KHZ 55
`define SLOW_RC_DIV ((`CORE_CLK_MHZ * 1000) / `SLOW_RC_KHZ)
`define BOOT_SLOW_CYCLES 12'hBB8

`define ADDR_CLOCK_MODE 8'h00
`define ADDR_FAST_TRIM 8'h04
`define ADDR_STATUS 8'h08

`define CLOCK_MODE_RESET 8'hE4
`define FAST_TRIM_RESET 8'h10
`define FAST_EN_BIT 4
`define SLOW_EN_BIT 2

`define MODE_DIV2 8'h34
`define MODE_DIV4 8'h14
`define MODE_DIV8 8'h3C
`define MODE_DIV16 8'h1C
`define MODE_DIV32 8'h7C
`define MODE_SLOW 8'hE4

`define SEL_DIV2 3'h0
`define SEL_DIV4 3'h1
`define SEL_DIV8 3'h2
`define SEL_DIV16 3'h3
`define SEL_DIV32 3'h4
`define SEL_SLOW 3'h7

`define RESET_VECTOR 11'h000
`define IRQ_VECTOR 11'h010

`endif

// ===== verilog/sysclk_boot_ctrl.v
// System clock source selection, divider, glitch-free switch and boot control
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`include "sysclk_boot_defs.vh"

// What this block does
// - Fast and slow oscillators enabled independently
// - After reset only slow oscillator runs
// - Hold core 3000 slow cycles after reset
// - Mode 34h selects fast divided by two
// - Mode 14h selects fast divided by four
// - Mode 3Ch selects fast divided by eight
// - Mode 1Ch selects fast divided by sixteen
// - Mode 7Ch selects fast divided by 32
// - Mode E4h selects undivided slow, fast off
// - Trim register adjusts fast oscillator frequency
// - Calibrated boot: watchdog off, slow on, pin input
// - Uncalibrated boot: mode untouched, watchdog on
// - First fetch comes from address zero
// - Accepted interrupt vectors to fixed entry
// - New mode takes effect at the first edge of the new source after write
module sysclk_boot_ctrl #(
	parameter SLOW_DIV = `SLOW_RC_DIV,
	parameter SLOW_W = 13
) (
	// Clock and reset
	input wire i_clk,
	input wire i_sys_rst,
	// APB register port
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [7:0] i_paddr,
	input wire [31:0] i_pwdata,
	output reg [31:0] o_prdata,
	output reg o_pready,
	output reg o_pslverr,
	// Calibration directive straps
	input wire i_calibration_directive_en,
	input wire [2:0] i_calibration_directive_sel,
	// Core side
	input wire i_irq_accept,
	output reg o_core_hold,
	output reg o_pc_load,
	output reg [10:0] o_pc_vector,
	// Clock and status outputs
	output reg o_sys_clk_en,
	output reg o_fast_rc_oscillator_en,
	output reg o_slow_rc_oscillator_en,
	output reg o_watchdog_en,
	output reg o_port_a_bit5_input
);

	function [2:0] mode_sel;
		input [7:0] mode;
		begin
			case ({mode[7:5], mode[3]})
				4'b0010: mode_sel = `SEL_DIV2;
				4'b0000: mode_sel = `SEL_DIV4;
				4'b0011: mode_sel = `SEL_DIV8;
				4'b0001: mode_sel = `SEL_DIV16;
				4'b0111: mode_sel = `SEL_DIV32;
				default: mode_sel = `SEL_SLOW;
			endcase
		end
	endfunction

	function [7:0] boot_mode;
		input [2:0] sel;
		begin
			case (sel)
				`SEL_DIV2: boot_mode = `MODE_DIV2;
				`SEL_DIV4: boot_mode = `MODE_DIV4;
				`SEL_DIV8: boot_mode = `MODE_DIV8;
				`SEL_DIV16: boot_mode = `MODE_DIV16;
				`SEL_DIV32: boot_mode = `MODE_DIV32;
				default: boot_mode = `MODE_SLOW;
			endcase
		end
	endfunction

	function [31:0] read_word;
		input [7:0] addr;
		input [7:0] mode;
		input [7:0] trim;
		input [7:0] stat;
		begin
			case (addr)
				`ADDR_CLOCK_MODE: read_word = {24'h00_0000, mode};
				`ADDR_FAST_TRIM: read_word = {24'h00_0000, trim};
				`ADDR_STATUS: read_word = {24'h00_0000, stat};
				default: read_word = 32'h0000_0000;
			endcase
		end
	endfunction

	function addr_mapped;
		input [7:0] addr;
		begin
			case (addr)
				`ADDR_CLOCK_MODE: addr_mapped = 1'b1;
				`ADDR_FAST_TRIM: addr_mapped = 1'b1;
				`ADDR_STATUS: addr_mapped = 1'b1;
				default: addr_mapped = 1'b0;
			endcase
		end
	endfunction

	// Registers seen by software
	reg [7:0] clock_mode_q;
	reg [7:0] fast_trim_q;

	// Oscillator models, divider and switch
	reg [2:0] active_sel_q;
	reg [SLOW_W-1:0] slow_cnt_q;
	reg slow_tick_q;
	reg [7:0] fast_cnt_q;
	reg fast_tick_q;
	reg [4:0] ratio_cnt_q;

	// Boot progress and synchronised straps
	reg [11:0] boot_cnt_q;
	reg boot_done_q;
	reg cal_en_m_q;
	reg cal_en_q;
	reg [2:0] cal_sel_m_q;
	reg [2:0] cal_sel_q;

	wire setup = i_psel & ~i_penable;
	wire access_done = i_psel & i_penable & o_pready;
	wire wr_mode = access_done & i_pwrite & (i_paddr == `ADDR_CLOCK_MODE);
	wire wr_trim = access_done & i_pwrite & (i_paddr == `ADDR_FAST_TRIM);
	wire [2:0] want_sel = mode_sel(clock_mode_q);
	wire fast_on = clock_mode_q[`FAST_EN_BIT];
	wire slow_on = clock_mode_q[`SLOW_EN_BIT];
	wire [7:0] fast_period = (fast_trim_q == 8'h00) ? 8'h01 : fast_trim_q;
	wire [4:0] ratio_last = (5'h02 << want_sel[2:0]) - 5'h01;
	wire new_fast_edge = fast_tick_q & (ratio_cnt_q == ratio_last);
	wire new_edge = (want_sel == `SEL_SLOW) ? slow_tick_q : new_fast_edge;
	wire [7:0] status = {3'h0, boot_done_q, (want_sel != active_sel_q), active_sel_q};
	wire boot_end = !boot_done_q & slow_tick_q & (boot_cnt_q == `BOOT_SLOW_CYCLES - 12'h001);

	// Enable strap synchroniser
	always @(posedge i_clk) begin
		cal_en_m_q <= i_calibration_directive_en;
		cal_en_q <= cal_en_m_q;
	end

	// Select strap synchroniser
	always @(posedge i_clk) begin
		cal_sel_m_q <= i_calibration_directive_sel;
		cal_sel_q <= cal_sel_m_q;
	end

	// APB slave, no wait states; read data and error are captured in the setup cycle
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_pready <= 1'b0;
			o_prdata <= 32'h0000_0000;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= setup;
			if (setup) begin
				o_prdata <= read_word(i_paddr, clock_mode_q, fast_trim_q, status);
				o_pslverr <= !addr_mapped(i_paddr);
			end
		end
	end

	// Clock mode register: a bus write wins over the boot-time setting
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			clock_mode_q <= `CLOCK_MODE_RESET;
		end else if (wr_mode) begin
			clock_mode_q <= i_pwdata[7:0];
		end else if (boot_end && cal_en_q) begin
			clock_mode_q <= boot_mode(cal_sel_q);
		end
	end

	// Fast oscillator trim register
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			fast_trim_q <= `FAST_TRIM_RESET;
		end else if (wr_trim) begin
			fast_trim_q <= i_pwdata[7:0];
		end
	end

	// Watchdog stays on unless a calibrated boot turns it off
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_watchdog_en <= 1'b1;
		end else if (boot_end && cal_en_q) begin
			o_watchdog_en <= 1'b0;
		end
	end

	// Port pin left in input mode after either kind of boot
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_port_a_bit5_input <= 1'b1;
		end else begin
			o_port_a_bit5_input <= 1'b1;
		end
	end

	// Slow oscillator model
	always @(posedge i_clk) begin
		if (i_sys_rst || !slow_on) begin
			slow_cnt_q <= {SLOW_W{1'b0}};
			slow_tick_q <= 1'b0;
		end else if (slow_cnt_q == SLOW_DIV[SLOW_W-1:0] - 1'b1) begin
			slow_cnt_q <= {SLOW_W{1'b0}};
			slow_tick_q <= 1'b1;
		end else begin
			slow_cnt_q <= slow_cnt_q + 1'b1;
			slow_tick_q <= 1'b0;
		end
	end

	// Fast oscillator model, period set by trim
	always @(posedge i_clk) begin
		if (i_sys_rst || !fast_on) begin
			fast_cnt_q <= 8'h00;
			fast_tick_q <= 1'b0;
		end else if (fast_cnt_q >= fast_period - 8'h01) begin
			fast_cnt_q <= 8'h00;
			fast_tick_q <= 1'b1;
		end else begin
			fast_cnt_q <= fast_cnt_q + 8'h01;
			fast_tick_q <= 1'b0;
		end
	end

	// Ratio counter over fast ticks; a mode write restarts it so no short period escapes
	always @(posedge i_clk) begin
		if (i_sys_rst || wr_mode) begin
			ratio_cnt_q <= 5'h00;
		end else if (fast_tick_q) begin
			if (ratio_cnt_q >= ratio_last) begin
				ratio_cnt_q <= 5'h00;
			end else begin
				ratio_cnt_q <= ratio_cnt_q + 5'h01;
			end
		end
	end

	// Glitch-free switch: while a change is pending only an edge of the new source passes,
	// so on a switch to a fast ratio the core never sees a period shorter than the new ratio; a switch to slow takes the next slow tick
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			active_sel_q <= `SEL_SLOW;
			o_sys_clk_en <= 1'b0;
		end else if (want_sel != active_sel_q) begin
			o_sys_clk_en <= new_edge;
			if (new_edge) begin
				active_sel_q <= want_sel;
			end
		end else begin
			o_sys_clk_en <= new_edge;
		end
	end

	// Oscillator enables follow the mode register
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_fast_rc_oscillator_en <= 1'b0;
			o_slow_rc_oscillator_en <= 1'b1;
		end else begin
			o_fast_rc_oscillator_en <= fast_on;
			o_slow_rc_oscillator_en <= slow_on;
		end
	end

	// Boot delay and program vectors
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			boot_cnt_q <= 12'h000;
			boot_done_q <= 1'b0;
			o_core_hold <= 1'b1;
			o_pc_load <= 1'b0;
			o_pc_vector <= `RESET_VECTOR;
		end else begin
			o_pc_load <= 1'b0;
			if (!boot_done_q) begin
				if (slow_tick_q) begin
					if (boot_cnt_q == `BOOT_SLOW_CYCLES - 12'h001) begin
						boot_done_q <= 1'b1;
						o_core_hold <= 1'b0;
						o_pc_load <= 1'b1;
						o_pc_vector <= `RESET_VECTOR;
					end else begin
						boot_cnt_q <= boot_cnt_q + 12'h001;
					end
				end
			end else if (i_irq_accept) begin
				o_pc_load <= 1'b1;
				o_pc_vector <= `IRQ_VECTOR;
			end
		end
	end

endmodule

// ===== sim/sysclk_boot_props.sv
// Assertions for the clock and boot block
`timescale 1ns/10ps
module sysclk_boot_props(
	// Clock, reset and bus
	input wire i_clk, input wire i_sys_rst, input wire i_psel, input wire i_penable,
	input wire [7:0] i_paddr, input wire o_pready, input wire o_pslverr,
	// Boot and core
	input wire i_irq_accept, input wire i_calibration_directive_en, input wire o_core_hold,
	input wire o_pc_load, input wire [10:0] o_pc_vector, input wire o_watchdog_en
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	a_pready_pulse: assert property (o_pready |=> !o_pready) else $error("pready held");
	a_pready_setup: assert property (i_psel && !i_penable |=> o_pready) else $error("no answer");
	a_slverr_unmapped: assert property (o_pready && i_paddr > 8'h08 |-> o_pslverr) else $error("no error");
	a_boot_vector: assert property ($fell(o_core_hold) |-> o_pc_load && o_pc_vector == 11'h000)
		else $error("bad boot vector");
	a_irq_vector: assert property (i_irq_accept && !o_core_hold |=> o_pc_load && o_pc_vector == 11'h010)
		else $error("bad irq vector");
	a_hold_quiet: assert property (o_core_hold |-> !o_pc_load) else $error("load in boot");
	a_hold_sticky: assert property (!o_core_hold |=> !o_core_hold) else $error("hold again");
	a_watchdog_boot: assert property ($fell(o_core_hold) |-> ##1 o_watchdog_en == !i_calibration_directive_en)
		else $error("bad watchdog");
endmodule
bind sysclk_boot_ctrl sysclk_boot_props u_props(.*);

// ===== sim/testbench.sv
// Self-checking bench for the clock and boot block
`timescale 1ns/10ps
module testbench;
	reg clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, irq = 0, cen = 1, re;
	reg [2:0] csel = 3'h1;
	reg [7:0] addr = 8'h00;
	reg [31:0] wd = 32'h0, r;
	wire [31:0] rd;
	wire [10:0] pcv;
	wire rdy, err, hold, pcl, tick, fen, sen, wdt, pin;
	integer miscompares = 0, n_tests = 0, cycles = 0, n, i;
	reg [55:0] codes = 56'h34143C1C7CF4E4;
	sysclk_boot_ctrl #(.SLOW_DIV(4)) dut(.i_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd), .o_prdata(rd), .o_pready(rdy), .o_pslverr(err),
		.i_calibration_directive_en(cen), .i_calibration_directive_sel(csel), .i_irq_accept(irq),
		.o_core_hold(hold), .o_pc_load(pcl), .o_pc_vector(pcv), .o_sys_clk_en(tick),
		.o_fast_rc_oscillator_en(fen), .o_slow_rc_oscillator_en(sen), .o_watchdog_en(wdt),
		.o_port_a_bit5_input(pin));
	always #2 clk = ~clk;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			miscompares = miscompares + 1;
			finish_test;
		end
	end
	task finish_test;
		begin
			if (miscompares == 0 && n_tests > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	task chk(input [31:0] s, input [31:0] e);
		begin
			n_tests = n_tests + 1;
			if (s !== e) begin
				miscompares = miscompares + 1;
				$display("wrong value at %0t: %h not %h", $time, s, e);
			end
		end
	endtask
	task tk;
		begin
			@(posedge clk);
			#1;
			n = n + 1;
		end
	endtask
	task apb(input w, input [7:0] a, input [31:0] d);
		begin
			@(posedge clk);
			psel <= 1;
			pwr <= w;
			addr <= a;
			wd <= d;
			@(posedge clk);
			pen <= 1;
			@(posedge clk);
			while (rdy !== 1'b1) @(posedge clk);
			r = rd;
			re = err;
			psel <= 0;
			pen <= 0;
		end
	endtask
	// Period between two system ticks once the new source is running
	task per(input integer e);
		begin
			tk;
			while (tick !== 1'b1) tk;
			n = 0;
			tk;
			while (tick !== 1'b1) tk;
			chk(n, e);
		end
	endtask
	task boot(input c);
		begin
			@(posedge clk);
			rst <= 1;
			cen <= c;
			repeat (12) @(posedge clk);
			#1;
			chk({hold, fen, sen, wdt, pin}, 5'h17);
			@(posedge clk);
			rst <= 0;
			n = 0;
			while (hold !== 1'b0) tk;
			chk(n > 11990 && n < 12010, 1);
			chk({pcl, pcv}, 12'h800);
			tk;
			tk;
			chk({wdt, fen, sen, pin}, {!c, c, 2'b11});
			apb(0, 8'h00, 0);
			chk(r, c ? 32'h14 : 32'hE4);
		end
	endtask
	task trim_test;
		begin
			apb(0, 8'h04, 0);
			chk(r, 32'h10);
			chk(re, 0);
			apb(1, 8'h04, 2);
			apb(0, 8'h04, 0);
			chk(r, 32'h2);
		end
	endtask
	task switch_test;
		begin
			for (i = 0; i < 7; i = i + 1) begin
				apb(1, 8'h00, codes[55 - 8 * i -: 8]);
				tk;
				chk({fen, sen}, {codes[52 - 8 * i], codes[50 - 8 * i]});
				per(i < 5 ? 4 << i : 4);
				apb(0, 8'h08, 0);
				chk(r[2:0], i < 5 ? i : 7);
			end
		end
	endtask
	task unmapped_test;
		begin
			apb(1, 8'h0C, 32'hFF);
			chk(re, 1);
			chk(r, 0);
		end
	endtask
	task irq_test;
		begin
			@(posedge clk);
			irq <= 1;
			@(posedge clk);
			irq <= 0;
			#1;
			chk({pcl, pcv}, 12'h810);
		end
	endtask
	initial begin
		boot(1);
		trim_test;
		switch_test;
		unmapped_test;
		irq_test;
		boot(0);
		finish_test;
	end
endmodule
